// ---- hdl/fault_monitor_params.svh ----
`ifndef FAULT_MONITOR_PARAMS_SVH
`define FAULT_MONITOR_PARAMS_SVH

// word indices; byte address is four times the index
`define IDX_RESET_MASK   10'h1D6
`define IDX_ALERT_MASK   10'h1D7
`define IDX_FAULT_STATUS 10'h1D8
`define IDX_IRQ_MASK     10'h1F0

// reset values
`define RST_RESET_MASK   16'hFFFF
`define RST_ALERT_MASK   16'hFFFF
`define RST_FAULT_STATUS 16'h0000
`define RST_IRQ_MASK     16'h0000

// field positions of the fault status register
`define LIVE_MSB         11
`define RSVD_MSB         15
`define RSVD_LSB         12
`define LIVE_BITS        12

// bus answer: cycles from request seen to waitrequest low
`define BUS_ACK_CYCLES   1

`endif

// ---- hdl/fault_monitor_pkg.sv ----
package fault_monitor_pkg;

    // one field per fault detector, msb first (bit 11 down to bit 0)
    typedef struct packed {
        logic pll_lockdetect_failure;
        logic system_clock_freq_unlock;
        logic system_clock_ppm_unlock;
        logic system_clock_dead;
        logic line_driver_txclock_dead;
        logic pll_output_freq_unlock;
        logic pll_output_ppm_unlock;
        logic pll_output_clock_dead;
        logic recovered_clock_dead;
        logic converter_clock_dead;
        logic power_mgmt_fault;
        logic reset_control_fault;
    } fault_vec_t;

    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avmm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avmm_rsp_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage

// ---- hdl/sefi_fault_status_monitor.sv ----
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "fault_monitor_params.svh"

module sefi_fault_status_monitor
    import fault_monitor_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire avmm_req_t  bus_req,
    output avmm_rsp_t       bus_rsp,
    input  wire fault_vec_t fault_in,
    output logic            recovery_alert_out_n,
    output logic            soft_recovery_req,
    output logic            irq
);

    // =========================================================
    // address decode
    // =========================================================
    function automatic logic idx_hit(input logic [11:0] addr,
                                     input logic [9:0]  idx);
        idx_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    wire logic hit_reset_mask;
    wire logic hit_alert_mask;
    wire logic hit_status;
    wire logic hit_irq_mask;

    assign hit_reset_mask = idx_hit(bus_req.address, `IDX_RESET_MASK);
    assign hit_alert_mask = idx_hit(bus_req.address, `IDX_ALERT_MASK);
    assign hit_status     = idx_hit(bus_req.address, `IDX_FAULT_STATUS);
    assign hit_irq_mask   = idx_hit(bus_req.address, `IDX_IRQ_MASK);

    // =========================================================
    // bus handshake
    // =========================================================
    bus_state_t  bus_state_ff;
    bus_state_t  nxt_bus_state;
    logic        waitrequest_ff;
    logic        nxt_waitrequest;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;

    wire logic   req_seen;
    wire logic   write_fire;
    wire logic   read_load;
    wire logic [15:0] lane_mask;
    wire logic [15:0] wr_merge_reset;
    wire logic [15:0] wr_merge_alert;
    wire logic [15:0] wr_merge_irq;

    assign req_seen   = bus_req.read | bus_req.write;
    assign write_fire = (bus_state_ff == BUS_ACK) & bus_req.write;
    assign read_load  = (bus_state_ff == BUS_IDLE) & bus_req.read;
    assign lane_mask  = {{8{bus_req.byteenable[1]}},
                         {8{bus_req.byteenable[0]}}};

    // request is answered one cycle after it is seen, then released
    always_comb begin
        nxt_bus_state   = bus_state_ff;
        nxt_waitrequest = waitrequest_ff;
        case (bus_state_ff)
            BUS_IDLE: begin
                if (req_seen) begin
                    nxt_bus_state   = BUS_ACK;
                    nxt_waitrequest = 1'b0;
                end
            end
            BUS_ACK: begin
                nxt_bus_state   = BUS_IDLE;
                nxt_waitrequest = 1'b1;
            end
            default: begin
                nxt_bus_state   = BUS_IDLE;
                nxt_waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bus_state_ff   <= BUS_IDLE;
            waitrequest_ff <= 1'b1;
        end else if (ce) begin
            bus_state_ff   <= nxt_bus_state;
            waitrequest_ff <= nxt_waitrequest;
        end
    end

    // =========================================================
    // mask registers
    // =========================================================
    logic [15:0] reset_mask_ff;
    logic [15:0] alert_mask_ff;
    logic [15:0] irq_mask_ff;
    logic [15:0] nxt_reset_mask;
    logic [15:0] nxt_alert_mask;
    logic [15:0] nxt_irq_mask;

    assign wr_merge_reset = (reset_mask_ff & ~lane_mask)
                          | (bus_req.writedata[15:0] & lane_mask);
    assign wr_merge_alert = (alert_mask_ff & ~lane_mask)
                          | (bus_req.writedata[15:0] & lane_mask);
    assign wr_merge_irq   = (irq_mask_ff & ~lane_mask)
                          | (bus_req.writedata[15:0] & lane_mask);

    assign nxt_reset_mask = (write_fire & hit_reset_mask)
                          ? wr_merge_reset : reset_mask_ff;
    assign nxt_alert_mask = (write_fire & hit_alert_mask)
                          ? wr_merge_alert : alert_mask_ff;
    assign nxt_irq_mask   = (write_fire & hit_irq_mask)
                          ? wr_merge_irq : irq_mask_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reset_mask_ff <= `RST_RESET_MASK;
            alert_mask_ff <= `RST_ALERT_MASK;
            irq_mask_ff   <= `RST_IRQ_MASK;
        end else if (ce) begin
            reset_mask_ff <= nxt_reset_mask;
            alert_mask_ff <= nxt_alert_mask;
            irq_mask_ff   <= nxt_irq_mask;
        end
    end

    // =========================================================
    // sticky fault status
    // =========================================================
    logic [`LIVE_MSB:0] status_ff;
    logic [`LIVE_MSB:0] nxt_status;
    wire logic [`LIVE_MSB:0] fault_bits;
    wire logic [`LIVE_MSB:0] clear_bits;
    wire logic [15:0]        status_word;

    assign fault_bits = fault_in;
    assign clear_bits = (write_fire & hit_status)
                      ? (bus_req.writedata[`LIVE_MSB:0]
                         & lane_mask[`LIVE_MSB:0])
                      : {`LIVE_BITS{1'b0}};

    // one flag per detector; a new fault beats a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi <= `LIVE_MSB; gi++) begin : g_flag
            assign nxt_status[gi] = fault_bits[gi]
                                  | (status_ff[gi] & ~clear_bits[gi]);
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_ff <= `LIVE_BITS'(`RST_FAULT_STATUS);
        end else if (ce) begin
            status_ff <= nxt_status;
        end
    end

    assign status_word = {4'h0, status_ff};

    // =========================================================
    // read data
    // =========================================================
    wire logic [15:0] read_word;

    assign read_word = hit_reset_mask ? reset_mask_ff
                     : hit_alert_mask ? alert_mask_ff
                     : hit_status     ? status_word
                     : hit_irq_mask   ? irq_mask_ff
                     : 16'h0000;

    assign nxt_readdata = read_load ? {16'h0000, read_word} : readdata_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            readdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            readdata_ff <= nxt_readdata;
        end
    end

    assign bus_rsp.readdata    = readdata_ff;
    assign bus_rsp.waitrequest = waitrequest_ff;

    // =========================================================
    // recovery and interrupt outputs
    // =========================================================
    logic alert_n_ff;
    logic soft_req_ff;
    logic irq_ff;
    wire logic nxt_alert_n;
    wire logic nxt_soft_req;
    wire logic nxt_irq;

    assign nxt_alert_n  = ~|(nxt_status & nxt_alert_mask[`LIVE_MSB:0]);
    assign nxt_soft_req = |(nxt_status & nxt_reset_mask[`LIVE_MSB:0]);
    assign nxt_irq      = |(nxt_status & nxt_irq_mask[`LIVE_MSB:0]);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            alert_n_ff  <= 1'b1;
            soft_req_ff <= 1'b0;
            irq_ff      <= 1'b0;
        end else if (ce) begin
            alert_n_ff  <= nxt_alert_n;
            soft_req_ff <= nxt_soft_req;
            irq_ff      <= nxt_irq;
        end
    end

    assign recovery_alert_out_n = alert_n_ff;
    assign soft_recovery_req    = soft_req_ff;
    assign irq                  = irq_ff;

    // =========================================================
    // assertions
    // =========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    generate
        for (gi = 0; gi <= `LIVE_MSB; gi++) begin : g_chk
            a_fault_sets_flag: assert property (
                ce && fault_bits[gi] |=> status_ff[gi])
                else $error("fault did not set its status flag");
            a_flag_stays_set: assert property (
                ce && status_ff[gi] && !clear_bits[gi] |=> status_ff[gi])
                else $error("status flag dropped without a clear");
        end
    endgenerate

    a_w1c_clears_flag: assert property (
        ce && write_fire && hit_status && (clear_bits != 12'h000)
        |=> ((status_ff & $past(clear_bits))
             == ($past(fault_bits) & $past(clear_bits))))
        else $error("write of one did not clear the flag");

    a_reserved_read_zero: assert property (
        ce && read_load && hit_status
        |=> readdata_ff[31:12] == 20'h00000)
        else $error("reserved status bits read nonzero");

    a_reset_mask_init: assert property (disable iff (1'b0)
        !rstn |=> reset_mask_ff == 16'hFFFF)
        else $error("soft reset mask not all ones after reset");

    a_alert_mask_init: assert property (disable iff (1'b0)
        !rstn |=> alert_mask_ff == 16'hFFFF && recovery_alert_out_n)
        else $error("alert mask not all ones after reset");

    a_alert_gating: assert property (
        recovery_alert_out_n
        == !(|(status_ff & alert_mask_ff[`LIVE_MSB:0])))
        else $error("alert output disagrees with masked status");

    a_soft_gating: assert property (
        soft_recovery_req == (|(status_ff & reset_mask_ff[`LIVE_MSB:0])))
        else $error("soft recovery request disagrees with mask");

    a_mask_write_land: assert property (
        ce && write_fire && hit_alert_mask
        && bus_req.byteenable[1:0] == 2'h3
        |=> alert_mask_ff == $past(bus_req.writedata[15:0]))
        else $error("alert mask write was lost");

    a_wait_one_cycle: assert property (
        ce && waitrequest_ff && req_seen |=> !waitrequest_ff
        ##1 (waitrequest_ff || !ce))
        else $error("waitrequest low not exactly one cycle");

    c_fault_to_alert: cover property (
        ce && fault_bits[0] ##1 ce [*1] ##1 !recovery_alert_out_n);
    c_status_cleared: cover property (
        ce && status_ff != 12'h000 ##[1:20] status_ff == 12'h000);
    c_set_with_clear: cover property (
        ce && write_fire && hit_status && |(clear_bits & fault_bits));
    c_irq_raised: cover property (!irq ##1 irq);
    c_ce_held: cover property (ce ##1 !ce ##1 ce);

    // =========================================================
    // reset and clock enable checks
    // =========================================================
    a_status_reset_clear: assert property (disable iff (1'b0)
        !rstn |=> status_ff == 12'h000)
        else $error("status flags survived a reset");

    a_outputs_reset_idle: assert property (disable iff (1'b0)
        !rstn |=> !soft_recovery_req && !irq && waitrequest_ff)
        else $error("outputs not idle after reset");

    // a low enable must stall bus and flags alike
    a_ce_freezes_state: assert property (
        !ce |=> $stable(status_ff) && $stable(reset_mask_ff)
                && $stable(alert_mask_ff) && $stable(irq_mask_ff)
                && $stable(bus_state_ff) && $stable(readdata_ff))
        else $error("state moved while clock enable was low");

    a_bus_state_onehot: assert property (
        $onehot(bus_state_ff))
        else $error("bus state lost its one-hot code");

    a_no_ack_unasked: assert property (
        ce && waitrequest_ff && !req_seen |=> waitrequest_ff)
        else $error("waitrequest fell without a request");

    // =========================================================
    // register access checks
    // =========================================================
    a_soft_mask_land: assert property (
        ce && write_fire && hit_reset_mask
        && bus_req.byteenable[1:0] == 2'h3
        |=> reset_mask_ff == $past(bus_req.writedata[15:0]))
        else $error("soft reset mask write was lost");

    a_irq_mask_land: assert property (
        ce && write_fire && hit_irq_mask
        && bus_req.byteenable[1:0] == 2'h3
        |=> irq_mask_ff == $past(bus_req.writedata[15:0]))
        else $error("irq mask write was lost");

    // a cleared byte enable keeps that byte of the mask
    a_lane_keeps_byte: assert property (
        ce && write_fire && hit_reset_mask && !bus_req.byteenable[1]
        |=> reset_mask_ff[15:8] == $past(reset_mask_ff[15:8]))
        else $error("disabled byte lane of soft reset mask changed");

    a_misaligned_ignored: assert property (
        ce && write_fire && (bus_req.address[1:0] != 2'h0)
        |=> $stable(reset_mask_ff) && $stable(alert_mask_ff)
            && $stable(irq_mask_ff))
        else $error("misaligned write changed a mask");

    a_mask_read_back: assert property (
        ce && read_load && hit_reset_mask
        |=> readdata_ff[15:0] == $past(reset_mask_ff))
        else $error("soft reset mask read back wrong");

    a_alert_read_back: assert property (
        ce && read_load && hit_alert_mask
        |=> readdata_ff[15:0] == $past(alert_mask_ff))
        else $error("alert mask read back wrong");

    a_status_read_back: assert property (
        ce && read_load && hit_status
        |=> readdata_ff[15:0] == {4'h0, $past(status_ff)})
        else $error("fault status read back wrong");

    // read data must stand until the next read loads it
    a_readdata_holds: assert property (
        !(ce && read_load) |=> $stable(readdata_ff))
        else $error("read data changed without a read");

    a_irq_gating: assert property (
        irq == (|(status_ff & irq_mask_ff[`LIVE_MSB:0])))
        else $error("irq disagrees with masked status");

endmodule

// ---- sim/sefi_fault_status_monitor_tb.sv ----
`timescale 1ns/1ps
`include "fault_monitor_params.svh"

module sefi_fault_status_monitor_tb
    import fault_monitor_pkg::*;
;
    localparam logic [11:0] A_RST = {`IDX_RESET_MASK, 2'b00};
    localparam logic [11:0] A_ALT = {`IDX_ALERT_MASK, 2'b00};
    localparam logic [11:0] A_STS = {`IDX_FAULT_STATUS, 2'b00};
    localparam logic [11:0] A_IRQ = {`IDX_IRQ_MASK, 2'b00};

    logic        core_clk = 1'b0;
    logic        rstn;
    logic        ce;
    avmm_req_t   bus_req;
    avmm_rsp_t   bus_rsp;
    fault_vec_t  fault_in;
    logic        alert_n;
    logic        soft_req;
    logic        irq;
    logic [31:0] q;
    int          num_errors;
    int          checks_done;

    always #12.5 core_clk = ~core_clk;

    sefi_fault_status_monitor sefi_fault_status_monitor_i (
        .core_clk             (core_clk),
        .rstn                 (rstn),
        .ce                   (ce),
        .bus_req              (bus_req),
        .bus_rsp              (bus_rsp),
        .fault_in             (fault_in),
        .recovery_alert_out_n (alert_n),
        .soft_recovery_req    (soft_req),
        .irq                  (irq)
    );

    // ==========================================================
    // bench tasks
    task finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        bus_req.address <= a;
        bus_req.read <= !w;
        bus_req.write <= w;
        bus_req.writedata <= {16'h0000, d};
        @(posedge core_clk);
        while (bus_rsp.waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                num_errors++;
                finish_test();
            end
            @(posedge core_clk);
        end
        q = bus_rsp.readdata;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
        @(posedge core_clk);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 16'h0000);
        chk(nm, e, q);
    endtask

    task pulse(input logic [11:0] v);
        fault_in <= fault_vec_t'(v);
        @(posedge core_clk);
        fault_in <= '0;
        @(posedge core_clk);
    endtask

    // expected {alert_n, soft_req, irq}
    task outs(input logic [2:0] e, input string nm);
        chk(nm, {29'h0, e}, {29'h0, alert_n, soft_req, irq});
    endtask

    task do_reset;
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        bus_req = '0;
        bus_req.byteenable = 4'hF;
        fault_in = '0;
        num_errors = 0;
        checks_done = 0;
        do_reset();
        rd(A_RST, 32'h0000FFFF, "reset_mask");
        rd(A_ALT, 32'h0000FFFF, "alert_mask");
        rd(A_STS, 32'h00000000, "status");
        rd(A_IRQ, 32'h00000000, "irq_mask");
        outs(3'b100, "idle outputs");
        bus(1'b1, A_RST, 16'h1234);
        rd(A_RST, 32'h00001234, "reset_mask rw");
        bus(1'b1, A_ALT, 16'hA5C3);
        rd(A_ALT, 32'h0000A5C3, "alert_mask rw");
        bus(1'b1, A_RST, 16'hFFFF);
        bus(1'b1, A_ALT, 16'hFFFF);
        bus(1'b1, 12'h004, 16'hFFFF);
        rd(12'h004, 32'h00000000, "unmapped");
        rd(A_RST + 12'h001, 32'h00000000, "misaligned");
        bus(1'b1, A_RST + 12'h001, 16'h0000);
        bus_req.byteenable <= 4'h1;
        bus(1'b1, A_RST, 16'h0000);
        bus_req.byteenable <= 4'hF;
        rd(A_RST, 32'h0000FF00, "lane write");
        bus(1'b1, A_RST, 16'hFFFF);
        for (int k = 0; k < 12; k++) begin
            pulse(12'h001 << k);
            rd(A_STS, 32'h1 << k, "flag");
            outs(3'b010, "flag outputs");
            bus(1'b1, A_STS, 16'h0001 << k);
            rd(A_STS, 32'h00000000, "flag clear");
            outs(3'b100, "clear outputs");
        end
        pulse(12'hFFF);
        bus(1'b1, A_STS, 16'hF000);
        rd(A_STS, 32'h00000FFF, "reserved");
        bus(1'b1, A_STS, 16'h0001);
        rd(A_STS, 32'h00000FFE, "partial clear");
        bus(1'b1, A_STS, 16'hFFFF);
        rd(A_STS, 32'h00000000, "all clear");
        fault_in <= fault_vec_t'(12'h001);
        bus(1'b1, A_STS, 16'h0001);
        fault_in <= '0;
        rd(A_STS, 32'h00000001, "set beats clear");
        bus(1'b1, A_STS, 16'h0001);
        ce <= 1'b0;
        fault_in <= fault_vec_t'(12'h020);
        @(posedge core_clk);
        ce <= 1'b1;
        fault_in <= '0;
        rd(A_STS, 32'h00000000, "frozen flag");
        outs(3'b100, "frozen outputs");
        bus(1'b1, A_ALT, 16'h0004);
        bus(1'b1, A_RST, 16'h0010);
        bus(1'b1, A_IRQ, 16'h0010);
        pulse(12'h010);
        outs(3'b111, "gate bit4");
        pulse(12'h004);
        outs(3'b011, "gate bit2");
        bus(1'b1, A_IRQ, 16'h0000);
        outs(3'b010, "irq masked");
        bus(1'b1, A_STS, 16'h0010);
        outs(3'b000, "bit2 only");
        bus(1'b1, A_STS, 16'h0004);
        outs(3'b100, "none set");
        pulse(12'h800);
        do_reset();
        rd(A_STS, 32'h00000000, "status after reset");
        rd(A_ALT, 32'h0000FFFF, "alert_mask reset");
        rd(A_RST, 32'h0000FFFF, "reset_mask reset");
        finish_test();
    end
endmodule
